// ---- core/trc_defines.svh ----
`ifndef TRC_DEFINES_SVH
`define TRC_DEFINES_SVH

// register indices; avalon word address equals index, byte address is index times four
`define TRC_IDX_READ_SYNC_REQUEST 4'h2
`define TRC_IDX_CLR 4'h4
`define TRC_IDX_SET 4'h5
`define TRC_IDX_CHCFG 4'h6
`define TRC_IDX_DBG 4'h8
`define TRC_IDX_SYNCDATA 4'hA
`define TRC_IDX_STATUS 4'hB

// offsets that the read offset field may select
`define TRC_TGT_COUNT 5'h10
`define TRC_TGT_CC0 5'h18
`define TRC_TGT_CC1 5'h1A

// field positions
`define TRC_RR_TRIG 15
`define TRC_RR_CONT 14
`define TRC_CB_CMD_HI 7
`define TRC_CB_CMD_LO 6
`define TRC_CB_SINGLE 2
`define TRC_CB_DIR 0
`define TRC_CC_CAPT_HI 5
`define TRC_CC_CAPT_LO 4
`define TRC_CC_INV_HI 1
`define TRC_CC_INV_LO 0
`define TRC_DBG_RUN 0
`define TRC_ST_BUSY 0
`define TRC_ST_RUNNING 1

// reset values
`define TRC_RST_ADDR 5'h00
`define TRC_RST_CB 2'h0
`define TRC_RST_CH 2'h0

// prescaled timer clock: one tick every this many core_clk cycles
`define TRC_PRESC_DIV 8'h04

`endif

// ---- core/trc_pkg.sv ----
package trc_pkg;

   // run command encoding
   typedef enum logic [1:0] {
      TRC_CMD_NONE = 2'b00,
      TRC_CMD_RETRIGGER = 2'b01,
      TRC_CMD_STOP = 2'b10,
      TRC_CMD_RSVD = 2'b11
   } trc_cmd_t;

   // read synchronisation state
   typedef enum logic [0:0] {
      TRC_SYNC_IDLE = 1'b0,
      TRC_SYNC_BUSY = 1'b1
   } trc_sync_t;

endpackage

// ---- core/trc_run_control.sv ----
// Added by the designer: the Avalon-MM interface to the registers.
`include "trc_defines.svh"

module trc_run_control
   import trc_pkg::*;
(
   input wire logic core_clk, // 100 MHz core clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic softReset, // software reset pulse, keeps debug control
   input wire logic [3:0] avs_address, // avalon word address
   input wire logic avs_read, // avalon read request
   input wire logic avs_write, // avalon write request
   input wire logic [3:0] avs_byteenable, // avalon byte enables
   input wire logic [31:0] avs_writedata, // avalon write data
   output logic [31:0] avs_readdata, // avalon read data, registered
   output logic avs_waitrequest, // avalon wait request
   input wire logic [15:0] countValue, // live counter value from the core
   input wire logic [15:0] compareCapture0, // live channel 0 value
   input wire logic [15:0] compareCapture1, // live channel 1 value
   input wire logic wrapEvent, // counter overflow or underflow pulse
   input wire logic debugHalted, // cpu halted in debug mode
   input wire logic [1:0] waveformRaw, // waveform outputs before inversion
   output logic [1:0] waveformOut, // waveform outputs after inversion
   output logic [1:0] captureSelect, // per channel: 1 capture, 0 compare
   output logic countDown, // direction: 1 decrement, 0 increment
   output logic singlePass, // single pass mode active
   output logic counterRunning, // counter run state
   output logic retriggerPulse, // one tick-aligned retrigger pulse
   output logic stopPulse, // one tick-aligned stop pulse
   output logic timerEnable, // timer may advance this cycle
   output logic prescTick, // prescaled timer clock enable
   output logic [15:0] syncValue, // last synchronised register value
   output logic syncPending // sync pending flag
);

   logic ackReg;
   logic [7:0] prescCnt_reg;
   logic [1:0] cmd_reg;
   logic single_reg;
   logic dir_reg;
   logic [1:0] capt_reg;
   logic [1:0] inv_reg;
   logic run_when_halted_reg;
   logic cont_reg;
   logic [4:0] addr_reg;
   trc_sync_t sync_reg;
   logic [15:0] syncData_reg;
   logic running_reg;
   logic [31:0] readdata_reg;
   logic [1:0] waveOut_reg;
   logic retrig_reg;
   logic stop_reg;
   logic wrTake;
   logic rdTake;
   logic wrLane0;
   logic wrLane1;
   logic trigWrite;
   logic contChange;
   logic execNow;
   logic [15:0] targetValue;
   logic [1:0] cmdSetBits;
   logic [1:0] cmdClrBits;
   logic [1:0] cmd_next;
   logic [31:0] readdata_next;
   logic wrSet;
   logic wrClr;
   logic wrChcfg;
   logic wrDbg;
   logic wrReqLo;
   logic wrReqHi;
   logic [4:0] trigAddr;
   logic trigValid;

   // true for offsets that may be read-synchronised
   function automatic logic isSyncTarget(input logic [4:0] off);
      isSyncTarget = (off == `TRC_TGT_COUNT) || (off == `TRC_TGT_CC0) ||
                     (off == `TRC_TGT_CC1);
   endfunction

   // one byte lane of a completed write that hits a given register index
   function automatic logic laneHit(input logic lane,
                                    input logic [3:0] adr,
                                    input logic [3:0] idx);
      laneHit = lane && (adr == idx);
   endfunction

   // live value of the register at a sync offset, zero if not a target
   function automatic logic [15:0] targetMux(input logic [4:0] off,
                                             input logic [15:0] cnt,
                                             input logic [15:0] c0,
                                             input logic [15:0] c1);
      case (off)
         `TRC_TGT_COUNT: targetMux = cnt;
         `TRC_TGT_CC0: targetMux = c0;
         `TRC_TGT_CC1: targetMux = c1;
         default: targetMux = 16'h0000;
      endcase
   endfunction

   // shared view of both set and clear registers
   function automatic logic [31:0] ctrlView(input logic [1:0] cmd,
                                            input logic single,
                                            input logic dir);
      ctrlView = 32'h0000_0000;
      ctrlView[`TRC_CB_CMD_HI:`TRC_CB_CMD_LO] = cmd;
      ctrlView[`TRC_CB_SINGLE] = single;
      ctrlView[`TRC_CB_DIR] = dir;
   endfunction

   // bus handshake: every access answers in the second cycle
   assign avs_waitrequest = (avs_read | avs_write) & ~ackReg;
   assign wrTake = avs_write & ackReg;
   assign rdTake = avs_read & ~ackReg;
   assign wrLane0 = wrTake & avs_byteenable[0];
   assign wrLane1 = wrTake & avs_byteenable[1];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ackReg <= 1'b0;
      end else begin
         ackReg <= (avs_read | avs_write) & ~ackReg;
      end
   end

   // write strobes per register; a lane that is not enabled leaves its bits untouched
   assign wrSet = laneHit(wrLane0, avs_address, `TRC_IDX_SET);
   assign wrClr = laneHit(wrLane0, avs_address, `TRC_IDX_CLR);
   assign wrChcfg = laneHit(wrLane0, avs_address, `TRC_IDX_CHCFG);
   assign wrDbg = laneHit(wrLane0, avs_address, `TRC_IDX_DBG);
   assign wrReqLo = laneHit(wrLane0, avs_address, `TRC_IDX_READ_SYNC_REQUEST);
   assign wrReqHi = laneHit(wrLane1, avs_address, `TRC_IDX_READ_SYNC_REQUEST);

   // prescaler divider; the tick stands in for the prescaled timer clock
   always_ff @(posedge core_clk) begin
      if (sys_rst || softReset) begin
         prescCnt_reg <= 8'h00;
      end else if (prescCnt_reg == `TRC_PRESC_DIV - 8'h01) begin
         prescCnt_reg <= 8'h00;
      end else begin
         prescCnt_reg <= prescCnt_reg + 8'h01;
      end
   end
   assign prescTick = (prescCnt_reg == `TRC_PRESC_DIV - 8'h01) & timerEnable;

   // the timer halts in debug unless told to run on
   assign timerEnable = ~debugHalted | run_when_halted_reg;

   // command bits written through each view
   assign cmdSetBits = wrSet ?
                       avs_writedata[`TRC_CB_CMD_HI:`TRC_CB_CMD_LO] : 2'b00;
   assign cmdClrBits = wrClr ?
                       avs_writedata[`TRC_CB_CMD_HI:`TRC_CB_CMD_LO] : 2'b00;
   assign execNow = prescTick && (cmd_reg != TRC_CMD_NONE);

   // next pending command; a set arriving with execution survives as a new command
   always_comb begin
      cmd_next = cmd_reg & ~cmdClrBits;
      if (execNow) begin
         cmd_next = TRC_CMD_NONE;
      end
      cmd_next = cmd_next | cmdSetBits;
   end

   // pending command register, one state behind both views
   always_ff @(posedge core_clk) begin
      if (sys_rst || softReset) begin
         cmd_reg <= `TRC_RST_CB;
      end else begin
         cmd_reg <= cmd_next;
      end
   end

   // command decode; the reserved code is dropped without effect
   always_ff @(posedge core_clk) begin
      if (sys_rst || softReset) begin
         retrig_reg <= 1'b0;
         stop_reg <= 1'b0;
      end else begin
         retrig_reg <= execNow && (cmd_reg == TRC_CMD_RETRIGGER);
         stop_reg <= execNow && (cmd_reg == TRC_CMD_STOP);
      end
   end
   assign retriggerPulse = retrig_reg;
   assign stopPulse = stop_reg;

   // single pass, one shared state behind both views
   always_ff @(posedge core_clk) begin
      if (sys_rst || softReset) begin
         single_reg <= 1'b0;
      end else if (wrSet) begin
         single_reg <= single_reg | avs_writedata[`TRC_CB_SINGLE];
      end else if (wrClr) begin
         single_reg <= single_reg & ~avs_writedata[`TRC_CB_SINGLE];
      end
   end

   // count direction; zeros written through either view leave it as it was
   always_ff @(posedge core_clk) begin
      if (sys_rst || softReset) begin
         dir_reg <= 1'b0;
      end else if (wrSet) begin
         dir_reg <= dir_reg | avs_writedata[`TRC_CB_DIR];
      end else if (wrClr) begin
         dir_reg <= dir_reg & ~avs_writedata[`TRC_CB_DIR];
      end
   end
   assign singlePass = single_reg;
   assign countDown = dir_reg;

   // run state: single pass stops after the wrap that ends the pass
   always_ff @(posedge core_clk) begin
      if (sys_rst || softReset) begin
         running_reg <= 1'b0;
      end else if (retrig_reg) begin
         running_reg <= 1'b1;
      end else if (stop_reg) begin
         running_reg <= 1'b0;
      end else if (wrapEvent && single_reg && timerEnable) begin
         running_reg <= 1'b0;
      end
   end
   assign counterRunning = running_reg;

   // capture select per channel, two channels
   always_ff @(posedge core_clk) begin
      if (sys_rst || softReset) begin
         capt_reg <= `TRC_RST_CH;
      end else if (wrChcfg) begin
         capt_reg <= avs_writedata[`TRC_CC_CAPT_HI:`TRC_CC_CAPT_LO];
      end
   end

   // output invert per channel, written in the same access as capture select
   always_ff @(posedge core_clk) begin
      if (sys_rst || softReset) begin
         inv_reg <= `TRC_RST_CH;
      end else if (wrChcfg) begin
         inv_reg <= avs_writedata[`TRC_CC_INV_HI:`TRC_CC_INV_LO];
      end
   end
   assign captureSelect = capt_reg;

   // registered output inversion costs one cycle of waveform latency
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         waveOut_reg <= 2'b00;
      end else begin
         waveOut_reg <= waveformRaw ^ inv_reg;
      end
   end
   assign waveformOut = waveOut_reg;

   // debug control ignores software reset on purpose
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         run_when_halted_reg <= 1'b0;
      end else if (wrDbg) begin
         run_when_halted_reg <= avs_writedata[`TRC_DBG_RUN];
      end
   end

   // read request: offset in lane 0, continuous bit in lane 1
   always_ff @(posedge core_clk) begin
      if (sys_rst || softReset) begin
         addr_reg <= `TRC_RST_ADDR;
         cont_reg <= 1'b0;
      end else begin
         if (wrReqLo) begin
            addr_reg <= avs_writedata[4:0];
         end
         if (wrReqHi) begin
            cont_reg <= avs_writedata[`TRC_RR_CONT];
         end
      end
   end

   // trigger is a write-only strobe and is never stored
   assign trigWrite = wrReqHi && avs_writedata[`TRC_RR_TRIG];
   // an offset written in the same access as the trigger is the one that is synchronised
   assign trigAddr = wrReqLo ? avs_writedata[4:0] : addr_reg;
   assign trigValid = trigWrite && isSyncTarget(trigAddr);
   assign targetValue = targetMux(addr_reg, countValue, compareCapture0, compareCapture1);
   // continuous mode watches the live value against the last snapshot
   assign contChange = cont_reg && isSyncTarget(addr_reg) &&
                       (targetValue != syncData_reg);

   // sync engine: snapshot taken on the next timer tick, a new request wins over completion
   always_ff @(posedge core_clk) begin
      if (sys_rst || softReset) begin
         sync_reg <= TRC_SYNC_IDLE;
         syncData_reg <= 16'h0000;
      end else begin
         case (sync_reg)
            TRC_SYNC_IDLE: begin
               if (trigValid || contChange) begin
                  sync_reg <= TRC_SYNC_BUSY;
               end
            end
            TRC_SYNC_BUSY: begin
               if (prescTick) begin
                  syncData_reg <= targetValue;
                  if (!trigValid) begin
                     sync_reg <= TRC_SYNC_IDLE;
                  end
               end
            end
            default: begin
               sync_reg <= TRC_SYNC_IDLE;
            end
         endcase
      end
   end
   assign syncPending = (sync_reg == TRC_SYNC_BUSY);
   assign syncValue = syncData_reg;

   // read mux; reserved and unmapped positions stay zero
   always_comb begin
      readdata_next = 32'h0000_0000;
      case (avs_address)
         `TRC_IDX_READ_SYNC_REQUEST: begin
            readdata_next[`TRC_RR_CONT] = cont_reg; // trigger reads zero
            readdata_next[4:0] = addr_reg;
         end
         `TRC_IDX_CLR: readdata_next = ctrlView(cmd_reg, single_reg, dir_reg);
         `TRC_IDX_SET: readdata_next = ctrlView(cmd_reg, single_reg, dir_reg);
         `TRC_IDX_CHCFG: begin
            readdata_next[`TRC_CC_CAPT_HI:`TRC_CC_CAPT_LO] = capt_reg;
            readdata_next[`TRC_CC_INV_HI:`TRC_CC_INV_LO] = inv_reg;
         end
         `TRC_IDX_DBG: readdata_next[`TRC_DBG_RUN] = run_when_halted_reg;
         `TRC_IDX_SYNCDATA: readdata_next[15:0] = syncData_reg;
         `TRC_IDX_STATUS: begin
            readdata_next[`TRC_ST_BUSY] = syncPending;
            readdata_next[`TRC_ST_RUNNING] = running_reg;
         end
         default: readdata_next = 32'h0000_0000; // unmapped reads zero
      endcase
   end

   // read data registered in the wait cycle, stands at the answering edge
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         readdata_reg <= 32'h0000_0000;
      end else if (rdTake) begin
         readdata_reg <= readdata_next;
      end
   end
   assign avs_readdata = readdata_reg;

endmodule // trc_run_control

// ---- bench/trc_run_control_chk.sv ----
// watches the run-control ports; one clock domain, so defaults are set once
module trc_chk
   import trc_pkg::*;
(
   input wire logic core_clk, // core clock
   input wire logic sys_rst, // sync reset
   input wire logic softReset, // software reset
   input wire logic avs_read, // bus read
   input wire logic avs_write, // bus write
   input wire logic avs_waitrequest, // bus wait
   input wire logic debugHalted, // debug halt
   input wire logic timerEnable, // timer enable
   input wire logic prescTick, // prescaled tick
   input wire logic wrapEvent, // wrap pulse
   input wire logic singlePass, // single pass
   input wire logic counterRunning, // run state
   input wire logic retriggerPulse, // retrigger
   input wire logic stopPulse, // stop
   input wire logic syncPending // sync pending
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // bus: at most one wait cycle, none when idle
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer not after one wait cycle");
   a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait raised without request");
   // debug halt gates the prescaled clock
   a_run_free: assert property (!debugHalted |-> timerEnable)
      else $error("timer stopped outside debug halt");
   a_no_tick_halt: assert property (!timerEnable |-> !prescTick)
      else $error("tick while timer halted");
   a_tick_gap: assert property (prescTick |=> !prescTick [*3])
      else $error("prescaled ticks too close");
   // commands only leave on a prescaled tick; a retrigger leaves only once
   a_cmd_tick: assert property (retriggerPulse || stopPulse |-> $past(prescTick))
      else $error("command not aligned to tick");
   a_pulse_once: assert property (retriggerPulse |=> !retriggerPulse)
      else $error("command executed twice");
   a_cmd_excl: assert property (!(retriggerPulse && stopPulse))
      else $error("retrigger and stop together");
   a_stop_halt: assert property (stopPulse |=> !counterRunning)
      else $error("counter runs after stop");
   a_single_halt: assert property (wrapEvent && singlePass && !retriggerPulse && !prescTick
      && timerEnable && !softReset |=> !counterRunning)
      else $error("single pass did not halt at wrap");
   a_cont_wrap: assert property (wrapEvent && !singlePass && counterRunning && !prescTick
      && !stopPulse && !softReset |=> counterRunning)
      else $error("counter halted at wrap without single pass");

   c_retrig: cover property (retriggerPulse);
   c_stop: cover property (stopPulse);
   c_sync: cover property ($fell(syncPending));
endmodule // trc_chk

bind trc_run_control trc_chk chk_u (.core_clk, .sys_rst, .softReset, .avs_read, .avs_write,
   .avs_waitrequest, .debugHalted, .timerEnable, .prescTick, .wrapEvent, .singlePass,
   .counterRunning, .retriggerPulse, .stopPulse, .syncPending);

// ---- bench/trc_run_control_tb.sv ----
module trc_run_control_tb
   import trc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, sys_rst = 1'b1, softReset = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic avs_waitrequest, wrapEvent = 1'b0, debugHalted = 1'b0, countDown, singlePass;
   logic [15:0] countValue = 16'h0, compareCapture0 = 16'h0, compareCapture1 = 16'h0, syncValue;
   logic [1:0] waveformRaw = 2'h0, waveformOut, captureSelect;
   logic counterRunning, retriggerPulse, stopPulse, timerEnable, prescTick, syncPending;
   int errCount = 0, totalChecks = 0, nRet = 0, nStop = 0;

   trc_run_control dut_u (.core_clk, .sys_rst, .softReset, .avs_address, .avs_read, .avs_write,
      .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .countValue,
      .compareCapture0, .compareCapture1, .wrapEvent, .debugHalted, .waveformRaw, .waveformOut,
      .captureSelect, .countDown, .singlePass, .counterRunning, .retriggerPulse, .stopPulse,
      .timerEnable, .prescTick, .syncValue, .syncPending);

   always #5 core_clk = ~core_clk;

   // pulses last one cycle, so count them rather than poll
   always @(posedge core_clk) begin
      if (retriggerPulse === 1'b1) nRet <= nRet + 1;
      if (stopPulse === 1'b1) nStop <= nStop + 1;
   end

   task automatic finalReport();
      if (errCount == 0 && totalChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         errCount++;
         $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic limit(int n);
      if (n >= 20) begin
         errCount++;
         finalReport();
      end
   endtask

   task automatic wt(int n);
      repeat (n) @(posedge core_clk);
   endtask

   // one bus access; an edge passes first so a strobe is never driven twice in one step
   task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      limit(n);
   endtask

   task automatic wr(logic [3:0] a, logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdc(string nm, logic [3:0] a, logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask

   task automatic wrap();
      wrapEvent <= 1'b1;
      wt(1);
      wrapEvent <= 1'b0;
      wt(2);
   endtask

   task automatic s_regs();
      rdc("clr", 4'h4, 32'h0);
      rdc("chcfg", 4'h6, 32'h0);
      wr(4'h1, 32'hFF);
      rdc("unmapped", 4'h1, 32'h0);
      wr(4'h5, 32'h3F);
      rdc("set view", 4'h5, 32'h05);
      chk("dir", countDown, 1'b1);
      chk("single", singlePass, 1'b1);
      wr(4'h4, 32'h01);
      rdc("clr view", 4'h4, 32'h04);
      wr(4'h5, 32'h00);
      rdc("zeros", 4'h4, 32'h04);
      wr(4'h4, 32'h04);
      wt(1);
      chk("single off", singlePass, 1'b0);
      chk("dir up", countDown, 1'b0);
   endtask

   // every nonzero command code, then a cancel while ticks are frozen so no race with execution
   task automatic s_cmd();
      logic [1:0] c;
      int r0, s0;
      for (int i = 1; i < 4; i++) begin
         c = 2'(i);
         r0 = nRet;
         s0 = nStop;
         wr(4'h5, {24'h0, c, 6'h0});
         wt(8);
         chk("retrig", nRet - r0, c == 2'h1);
         chk("stop", nStop - s0, c == 2'h2);
         chk("running", counterRunning, c == 2'h1);
         rdc("cmd done", 4'h4, 32'h0);
      end
      debugHalted <= 1'b1;
      wr(4'h5, 32'h80);
      rdc("pending", 4'h4, 32'h80);
      wr(4'h4, 32'h40);
      rdc("kept", 4'h5, 32'h80);
      wr(4'h4, 32'h80);
      s0 = nStop;
      debugHalted <= 1'b0;
      wt(8);
      rdc("cancel", 4'h5, 32'h0);
      chk("no stop", nStop - s0, 0);
   endtask

   task automatic s_chan();
      wr(4'h6, 32'hFF);
      rdc("chcfg", 4'h6, 32'h33);
      chk("capture", captureSelect, 2'h3);
      waveformRaw <= 2'h1;
      wt(3);
      chk("inv both", waveformOut, 2'h2);
      wr(4'h6, 32'h12);
      wt(2);
      chk("cap0 only", captureSelect, 2'h1);
      chk("inv one", waveformOut, 2'h3);
   endtask

   task automatic s_dbg();
      debugHalted <= 1'b1;
      wt(2);
      chk("halted", timerEnable, 1'b0);
      wr(4'h8, 32'hFF);
      rdc("dbg", 4'h8, 32'h01);
      chk("run halted", timerEnable, 1'b1);
      softReset <= 1'b1;
      wt(1);
      softReset <= 1'b0;
      rdc("dbg kept", 4'h8, 32'h01);
      rdc("chcfg reset", 4'h6, 32'h0);
      wr(4'h8, 32'h0);
      debugHalted <= 1'b0;
   endtask

   task automatic wsync();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (syncPending !== 1'b0 && n < 20);
      limit(n);
   endtask

   task automatic s_sync();
      countValue <= 16'h1234;
      wr(4'h2, 32'h8010);
      wt(1);
      chk("pending", syncPending, 1'b1);
      wsync();
      chk("sync out", syncValue, 32'h1234);
      rdc("sync data", 4'hA, 32'h1234);
      rdc("trigger zero", 4'h2, 32'h0010);
      wr(4'h2, 32'h4018);
      compareCapture0 <= 16'hBEEF;
      wt(2);
      wsync();
      rdc("continuous", 4'hA, 32'hBEEF);
      rdc("offset", 4'h2, 32'h4018);
      wr(4'h2, 32'h0018);
      compareCapture0 <= 16'h1111;
      wt(8);
      rdc("no resync", 4'hA, 32'hBEEF);
      wr(4'h2, 32'hC005);
      wt(8);
      rdc("bad offset", 4'hA, 32'hBEEF);
      chk("not pending", syncPending, 1'b0);
   endtask

   // the same wrap with and without single pass
   task automatic s_single();
      wr(4'h5, 32'h44);
      wt(8);
      chk("started", counterRunning, 1'b1);
      rdc("status run", 4'hB, 32'h2);
      wrap();
      chk("one pass", counterRunning, 1'b0);
      wr(4'h4, 32'h04);
      wr(4'h5, 32'h40);
      wt(8);
      wrap();
      chk("keeps", counterRunning, 1'b1);
   endtask

   initial begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      s_regs();
      s_cmd();
      s_chan();
      s_dbg();
      s_sync();
      s_single();
      finalReport();
   end
endmodule // trc_run_control_tb
